//--- core/nvm_controller.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
// Summary of operation
// RULE_01: single ready vector at offset zero
// RULE_02: ready condition sets the ready flag
// RULE_03: irq while flag and enable, until cleared
// RULE_04: irq only with global enable set
// RULE_05: sleep with system when nothing writes
// RULE_06: write in progress keeps clock running
// RULE_07: ready irq wakes from idle only
// RULE_08: wake-up clears the page buffer
// RULE_09: command write needs key within four instructions
// RULE_10: three-bit command field issues commands
// RULE_11: address selects target array for page ops
// RULE_12: chip erase spares eeprom when fuse set
// RULE_13: fuse write only from debug port
// RULE_14: boot lock blanks boot reads and fetches
// RULE_15: boot lock written from boot, reset clears
// RULE_16: lock effective once boot section left
// RULE_17: app protect set-only, blocks app writes
// RULE_18: write error reflects most recent operation
// RULE_19: eeprom busy while eeprom executes
// RULE_20: flash busy while flash executes
// RULE_21: enabled ready irq repeats while eeprom idle
// RULE_22: write one clears ready flag
// RULE_23: page loads update the address register
// RULE_24: busy fall sets flag, done clears busy
// RULE_25: command to busy memory flags error
module nvm_controller
    import nvm_pkg::*;
#(
    parameter int          PAGE_CYC   = PAGE_OP_CYC,
    parameter int          LONG_CYC   = LONG_OP_CYC,
    parameter int          CLEAR_CYC  = BUF_CLEAR_CLKS,
    parameter logic [15:0] EE_FIRST   = 16'h1400,
    parameter logic [15:0] EE_LAST    = 16'h14FF,
    parameter logic [15:0] BOOT_FIRST = 16'h8000,
    parameter logic [15:0] APP_FIRST  = 16'h8800
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu side
    input  wire logic        key_written,
    input  wire logic        instr_retired,
    input  wire logic        debug_access,
    input  wire logic        exec_in_boot,
    input  wire logic        global_irq_en,
    // page buffer loads and reads
    input  wire logic        store_valid,
    input  wire logic [15:0] store_addr,
    input  wire logic        read_valid,
    input  wire logic [15:0] read_data,
    input  wire logic        keep_eeprom_fuse,
    // sleep
    input  wire logic        sleep_req,
    input  wire logic        sleep_idle_mode,
    output logic             nvm_asleep,
    output logic             clock_hold,
    output logic             wake_req,
    // array operations
    output logic             op_start,
    output logic [2:0]       op_cmd,
    output logic             op_to_eeprom,
    output logic             op_wipe_eeprom,
    output logic [15:0]      op_addr,
    output logic [15:0]      op_data,
    output logic             buffer_clear,
    output logic             boot_read_blank,
    output logic             app_write_block,
    output logic             eeprom_ready_irq
);
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // operation timers, one per memory
    op_if u_op [MEM_N] ();
    logic [MEM_N-1:0]             start_r;
    logic [MEM_N-1:0][CNT_W-1:0] cyc_r;
    logic [MEM_N-1:0]             busy;
    logic [MEM_N-1:0]             done;

    genvar g;
    generate
        for (g = 0; g < MEM_N; g++)
        begin : g_mem
            assign u_op[g].start  = start_r[g];
            assign u_op[g].cycles = cyc_r[g];
            assign busy[g]        = u_op[g].busy;
            assign done[g]        = u_op[g].done;
            nvm_op_timer u_timer
            (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .op      (u_op[g].timer)
            );
        end
    endgenerate

    // bus decode
    logic       acc_phase;
    logic       wr_fire;
    logic [3:0] idx;
    logic       mapped;

    assign acc_phase = psel && penable;
    assign wr_fire   = acc_phase && pready && pwrite;
    assign idx       = paddr[ADDR_LSB+3:ADDR_LSB];
    assign mapped    = (paddr[ADDR_LSB-1:0] == 2'b00) && (paddr[11:ADDR_LSB+4] == '0)
                       && (idx <= IDX_IFLAG || idx == IDX_DATA || idx == IDX_ADDR);

    logic       app_wp_r;
    logic       boot_wr_r;
    logic       boot_act_r;
    logic       werr_r;
    logic       ien_r;
    logic       flag_r;
    logic [15:0] data_r;
    logic [15:0] addr_r;
    logic [2:0]  cmd_r;
    logic [2:0]  unlock_r;
    logic        loaded_r;
    logic        loaded_ee_r;
    logic        mix_err_r;
    logic        ee_busy_d_r;
    logic        asleep_d_r;

    // unlock window counted in retired instructions
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            unlock_r <= '0;
        else if (key_written)
            unlock_r <= UNLOCK_INSTR; // RULE_09
        else if (wr_fire && idx == IDX_CMD)
            unlock_r <= '0;
        else if (instr_retired && unlock_r != '0)
            unlock_r <= unlock_r - 3'h1;
    end

    // command issue
    logic       cmd_wr;
    nvm_cmd_t   cmd_new;
    logic       tgt_ee;
    logic       cmd_err;
    logic       issue;

    assign cmd_wr  = wr_fire && idx == IDX_CMD && pstrb[0]
                     && (unlock_r != '0 || debug_access); // RULE_09
    assign cmd_new = nvm_cmd_t'(pwdata[CMD_LSB+CMD_W-1:CMD_LSB]); // RULE_10
    assign tgt_ee  = addr_r >= EE_FIRST && addr_r <= EE_LAST; // RULE_11
    assign issue   = cmd_wr && cmd_new != CMD_NONE;

    always_comb
    begin
        cmd_err = 1'b0;
        case (cmd_new)
            CMD_PAGE_WRITE, CMD_ERASE_WRITE:
                cmd_err = busy[tgt_ee ? MEM_EE : MEM_FLASH] || mix_err_r // RULE_25
                          || (loaded_r && loaded_ee_r != tgt_ee) // RULE_18
                          || (!tgt_ee && app_wp_r && addr_r >= APP_FIRST); // RULE_17
            CMD_PAGE_ERASE:
                cmd_err = busy[tgt_ee ? MEM_EE : MEM_FLASH]
                          || (!tgt_ee && app_wp_r && addr_r >= APP_FIRST);
            CMD_BUF_CLEAR:
                cmd_err = busy[MEM_FLASH];
            CMD_CHIP_ERASE:
                cmd_err = busy[MEM_FLASH] || busy[MEM_EE]; // RULE_25
            CMD_EE_WIPE:
                cmd_err = busy[MEM_EE];
            CMD_FUSE_PROG:
                cmd_err = !debug_access || busy[MEM_FLASH]; // RULE_13
            default:
                cmd_err = 1'b0;
        endcase
    end

    // timer starts and operation strobes
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_r        <= '0;
            cyc_r          <= '0;
            op_start       <= 1'b0;
            op_cmd         <= CMD_NONE;
            op_to_eeprom   <= 1'b0;
            op_wipe_eeprom <= 1'b0;
            op_addr        <= RST_WORD;
            op_data        <= RST_WORD;
            cmd_r          <= CMD_NONE;
        end
        else
        begin
            start_r  <= '0;
            op_start <= 1'b0;
            if (cmd_wr)
                cmd_r <= cmd_new;
            if (issue && !cmd_err)
            begin
                op_start       <= 1'b1;
                op_cmd         <= cmd_new;
                op_addr        <= addr_r;
                op_data        <= data_r;
                op_to_eeprom   <= 1'b0;
                op_wipe_eeprom <= 1'b0;
                case (cmd_new)
                    CMD_PAGE_WRITE, CMD_PAGE_ERASE, CMD_ERASE_WRITE:
                    begin
                        op_to_eeprom  <= tgt_ee; // RULE_11
                        start_r[tgt_ee ? MEM_EE : MEM_FLASH] <= 1'b1;
                        cyc_r[tgt_ee ? MEM_EE : MEM_FLASH] <=
                            (cmd_new == CMD_ERASE_WRITE) ? CNT_W'(LONG_CYC) : CNT_W'(PAGE_CYC);
                    end
                    CMD_BUF_CLEAR:
                    begin
                        start_r[MEM_FLASH] <= 1'b1;
                        cyc_r[MEM_FLASH]   <= CNT_W'(CLEAR_CYC);
                    end
                    CMD_CHIP_ERASE:
                    begin
                        start_r[MEM_FLASH] <= 1'b1;
                        cyc_r[MEM_FLASH]   <= CNT_W'(LONG_CYC);
                        op_wipe_eeprom     <= !keep_eeprom_fuse; // RULE_12
                        start_r[MEM_EE]    <= !keep_eeprom_fuse;
                        cyc_r[MEM_EE]      <= CNT_W'(LONG_CYC);
                    end
                    CMD_EE_WIPE:
                    begin
                        op_to_eeprom    <= 1'b1;
                        op_wipe_eeprom  <= 1'b1;
                        start_r[MEM_EE] <= 1'b1;
                        cyc_r[MEM_EE]   <= CNT_W'(LONG_CYC);
                    end
                    default:
                    begin
                        start_r[MEM_FLASH] <= 1'b1;
                        cyc_r[MEM_FLASH]   <= CNT_W'(PAGE_CYC);
                    end
                endcase
            end
        end
    end

    // write error holds the outcome of the latest command
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            werr_r <= 1'b0;
        else if (issue)
            werr_r <= cmd_err; // RULE_18
    end

    // page buffer clearing and load tracking
    logic wake_now;
    assign wake_now = asleep_d_r && !sleep_req;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            buffer_clear <= 1'b0;
        else
            buffer_clear <= (|done) || wake_now // RULE_08
                            || (issue && !cmd_err && cmd_new == CMD_BUF_CLEAR);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loaded_r    <= 1'b0;
            loaded_ee_r <= 1'b0;
            mix_err_r   <= 1'b0;
        end
        else if (buffer_clear)
        begin
            loaded_r  <= 1'b0;
            mix_err_r <= 1'b0;
        end
        else if (store_valid)
        begin
            loaded_r    <= 1'b1;
            loaded_ee_r <= store_addr >= EE_FIRST && store_addr <= EE_LAST;
            if (loaded_r && loaded_ee_r != (store_addr >= EE_FIRST && store_addr <= EE_LAST))
                mix_err_r <= 1'b1;
        end
    end

    // address and data words
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            addr_r <= RST_WORD;
        else if (store_valid)
            addr_r <= store_addr; // RULE_23
        else if (wr_fire && idx == IDX_ADDR)
        begin
            if (pstrb[0])
                addr_r[7:0] <= pwdata[7:0];
            if (pstrb[1])
                addr_r[15:8] <= pwdata[15:8];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            data_r <= RST_WORD;
        else if (read_valid)
            data_r <= read_data;
        else if (wr_fire && idx == IDX_DATA)
        begin
            if (pstrb[0])
                data_r[7:0] <= pwdata[7:0];
            if (pstrb[1])
                data_r[15:8] <= pwdata[15:8];
        end
    end

    // protection bits
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            app_wp_r   <= 1'b0;
            boot_wr_r  <= 1'b0;
            boot_act_r <= 1'b0;
        end
        else
        begin
            if (wr_fire && idx == IDX_PROT && pstrb[0])
            begin
                if (pwdata[PROT_APP_BIT])
                    app_wp_r <= 1'b1; // RULE_17
                if (pwdata[PROT_BOOT_BIT] && exec_in_boot)
                    boot_wr_r <= 1'b1; // RULE_15
            end
            if (boot_wr_r && !exec_in_boot)
                boot_act_r <= 1'b1; // RULE_16
        end
    end

    // interrupt flag and enable
    logic rdy_set;
    assign rdy_set = (ee_busy_d_r && !busy[MEM_EE]) // RULE_24
                     || (ien_r && !busy[MEM_EE]); // RULE_21

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ien_r       <= 1'b0;
            flag_r      <= 1'b0;
            ee_busy_d_r <= 1'b0;
        end
        else
        begin
            ee_busy_d_r <= busy[MEM_EE];
            if (wr_fire && idx == IDX_IEN && pstrb[0])
                ien_r <= pwdata[IRQ_RDY_BIT];
            if (rdy_set)
                flag_r <= 1'b1; // RULE_02
            else if (wr_fire && idx == IDX_IFLAG && pstrb[0] && pwdata[IRQ_RDY_BIT])
                flag_r <= 1'b0; // RULE_22
        end
    end

    // single ready vector; request held while flag, enable and global enable are all set
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            eeprom_ready_irq <= 1'b0;
        else
            eeprom_ready_irq <= flag_r && ien_r && global_irq_en; // RULE_01 RULE_03 RULE_04
    end

    // sleep handling
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nvm_asleep <= 1'b0;
            clock_hold <= 1'b0;
            wake_req   <= 1'b0;
            asleep_d_r <= 1'b0;
        end
        else
        begin
            asleep_d_r <= nvm_asleep;
            nvm_asleep <= sleep_req && !(|busy); // RULE_05
            clock_hold <= sleep_req && (|busy); // RULE_06
            wake_req   <= sleep_req && sleep_idle_mode
                          && flag_r && ien_r && global_irq_en; // RULE_07
        end
    end

    // misc outputs
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            boot_read_blank <= 1'b0;
            app_write_block <= 1'b0;
        end
        else
        begin
            boot_read_blank <= boot_act_r; // RULE_14
            app_write_block <= app_wp_r;
        end
    end

    // apb answer: one wait state
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = '0;
        case (idx)
            IDX_CMD:    rd_mux[CMD_W-1:0] = cmd_r;
            IDX_PROT:   rd_mux[1:0] = {boot_wr_r, app_wp_r};
            IDX_STATUS: rd_mux[2:0] = {werr_r, busy[MEM_EE], busy[MEM_FLASH]}; // RULE_19 RULE_20
            IDX_IEN:    rd_mux[IRQ_RDY_BIT] = ien_r;
            IDX_IFLAG:  rd_mux[IRQ_RDY_BIT] = flag_r;
            IDX_DATA:   rd_mux[15:0] = data_r;
            IDX_ADDR:   rd_mux[15:0] = addr_r;
            default:    rd_mux = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= acc_phase && !pready;
            pslverr <= acc_phase && !pready && !mapped;
            if (acc_phase && !pready && !pwrite)
                prdata <= mapped ? rd_mux : '0;
        end
    end
endmodule

//--- core/nvm_pkg.sv
package nvm_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CMD    = 4'h0;
    localparam logic [3:0] IDX_PROT   = 4'h1;
    localparam logic [3:0] IDX_STATUS = 4'h2;
    localparam logic [3:0] IDX_IEN    = 4'h3;
    localparam logic [3:0] IDX_IFLAG  = 4'h4;
    localparam logic [3:0] IDX_DATA   = 4'h6;
    localparam logic [3:0] IDX_ADDR   = 4'h8;
    localparam int         ADDR_LSB   = 2;

    // field positions
    localparam int CMD_LSB      = 0;
    localparam int CMD_W        = 3;
    localparam int PROT_APP_BIT = 0;
    localparam int PROT_BOOT_BIT = 1;
    localparam int ST_FLASH_BUSY_BIT = 0;
    localparam int ST_EBUSY_BIT = 1;
    localparam int ST_WERR_BIT  = 2;
    localparam int IRQ_RDY_BIT  = 0;
    localparam int IRQ_VECTOR   = 0;

    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [2:0] {
        CMD_NONE        = 3'b000,
        CMD_PAGE_WRITE  = 3'b001,
        CMD_PAGE_ERASE  = 3'b010,
        CMD_ERASE_WRITE = 3'b011,
        CMD_BUF_CLEAR   = 3'b100,
        CMD_CHIP_ERASE  = 3'b101,
        CMD_EE_WIPE     = 3'b110,
        CMD_FUSE_PROG   = 3'b111
    } nvm_cmd_t;

    // unlock window length in instructions
    localparam logic [2:0] UNLOCK_INSTR = 3'h4;

    // operation times
    localparam int CLK_PERIOD_NS  = 50;
    localparam int PAGE_OP_NS     = 2000000;
    localparam int LONG_OP_NS     = 4000000;
    localparam int BUF_CLEAR_CLKS = 7;
    localparam int PAGE_OP_CYC    = PAGE_OP_NS / CLK_PERIOD_NS;
    localparam int LONG_OP_CYC    = LONG_OP_NS / CLK_PERIOD_NS;
    localparam int CNT_W          = 32;

    localparam int MEM_FLASH = 0;
    localparam int MEM_EE    = 1;
    localparam int MEM_N     = 2;
endpackage

//--- core/op_if.sv
`timescale 1ns/10ps
interface op_if;
    import nvm_pkg::*;
    logic             start;
    logic [CNT_W-1:0] cycles;
    logic             busy;
    logic             done;
    modport ctrl  (output start, output cycles, input busy, input done);
    modport timer (input start, input cycles, output busy, output done);
endinterface

//--- core/nvm_op_timer.sv
`timescale 1ns/10ps
module nvm_op_timer
    import nvm_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // operation
    op_if.timer       op
);
    logic [CNT_W-1:0] cnt_r;

    // busy from start until the count expires; done pulses at the end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r   <= '0;
            op.busy <= 1'b0;
            op.done <= 1'b0;
        end
        else
        begin
            op.done <= 1'b0;
            if (op.start && !op.busy)
            begin
                cnt_r   <= op.cycles;
                op.busy <= 1'b1;
            end
            else if (op.busy)
            begin
                if (cnt_r <= CNT_W'(1))
                begin
                    op.busy <= 1'b0;
                    op.done <= 1'b1;
                    cnt_r   <= '0;
                end
                else
                begin
                    cnt_r <= cnt_r - CNT_W'(1);
                end
            end
        end
    end
endmodule

//--- bench/cpu_model.sv
`timescale 1ns/10ps
module cpu_model
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // bench request
    input  wire logic unlock,
    // to controller
    output logic      key_written,
    output logic      instr_retired
);
    logic phase_r;

    // one instruction every other cycle
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            phase_r       <= 1'b0;
            instr_retired <= 1'b0;
        end
        else
        begin
            phase_r       <= !phase_r;
            instr_retired <= phase_r;
        end
    end

    // key lands just before the command write
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            key_written <= 1'b0;
        else
            key_written <= unlock;
    end
endmodule

//--- bench/nvm_controller_sva.sv
`timescale 1ns/10ps
module nvm_checker
    import nvm_pkg::*;
#(
    parameter logic [15:0] EE_FIRST = 16'h1400,
    parameter logic [15:0] EE_LAST  = 16'h14FF
)
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       arst_n,
    // cpu side
    input wire logic       debug_access,
    input wire logic       exec_in_boot,
    input wire logic       global_irq_en,
    input wire logic       keep_eeprom_fuse,
    input wire logic       sleep_req,
    // outputs
    input wire logic       nvm_asleep,
    input wire logic       buffer_clear,
    input wire logic       op_start,
    input wire logic [2:0] op_cmd,
    input wire logic       op_to_eeprom,
    input wire logic       op_wipe_eeprom,
    input wire logic [15:0] op_addr,
    input wire logic       boot_read_blank,
    input wire logic       app_write_block,
    input wire logic       eeprom_ready_irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    chk_irq_global: assert property (eeprom_ready_irq |-> $past(global_irq_en))
        else $error("irq without global enable");
    chk_fuse_debug: assert property (op_start && op_cmd == CMD_FUSE_PROG
        |-> debug_access || $past(debug_access) || $past(debug_access, 2))
        else $error("fuse write from cpu");
    chk_chip_keep: assert property (op_start && op_cmd == CMD_CHIP_ERASE
        |-> op_wipe_eeprom == !keep_eeprom_fuse)
        else $error("chip erase eeprom choice wrong");
    chk_array_target: assert property (op_start && op_cmd inside {3'h1, 3'h2, 3'h3}
        |-> op_to_eeprom == (op_addr inside {[EE_FIRST:EE_LAST]}))
        else $error("page op target wrong");
    chk_op_pulse: assert property (op_start |=> !op_start)
        else $error("op start longer than one cycle");
    chk_app_sticky: assert property (app_write_block |=> app_write_block)
        else $error("app protect cleared");
    chk_boot_sticky: assert property (boot_read_blank |=> boot_read_blank)
        else $error("boot lock cleared");
    chk_boot_leave: assert property ($rose(boot_read_blank) |-> !$past(exec_in_boot, 2))
        else $error("boot lock active inside boot");
    chk_wake_clear: assert property ($fell(sleep_req) && nvm_asleep
        |-> ##[0:4] buffer_clear)
        else $error("no buffer clear on wake");

    cov_chip: cover property (op_start && op_cmd == CMD_CHIP_ERASE);
    cov_boot: cover property ($rose(boot_read_blank));
    cov_irq: cover property ($rose(eeprom_ready_irq));
endmodule

bind nvm_controller nvm_checker #(.EE_FIRST(EE_FIRST), .EE_LAST(EE_LAST)) chk (.*);

//--- bench/nvm_controller_bench.sv
`timescale 1ns/10ps
module nvm_controller_bench
    import nvm_pkg::*;
;
    logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        unlock, key_written, instr_retired, debug_access, exec_in_boot;
    logic        global_irq_en, store_valid, keep_eeprom_fuse, sleep_req, sleep_idle_mode;
    logic [15:0] store_addr;
    logic        nvm_asleep, clock_hold, boot_read_blank, app_write_block, eeprom_ready_irq;
    int          num_errors, n_compared, cycles, i;

    nvm_controller #(.PAGE_CYC(20), .LONG_CYC(40)) DUT (.*, .pstrb(4'hF), .read_valid(1'b0),
        .read_data(16'h0000), .wake_req(), .op_start(), .op_cmd(), .op_to_eeprom(),
        .op_wipe_eeprom(), .op_addr(), .op_data(), .buffer_clear());

    cpu_model cpu (.sys_clk(sys_clk), .arst_n(arst_n), .unlock(unlock),
        .key_written(key_written), .instr_retired(instr_retired));

    function automatic logic [11:0] ba(input logic [3:0] idx);
        return {6'h00, idx, 2'b00};
    endfunction

    task automatic summarize();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // apb transfer, answer taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge sys_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        cmp(q, exp);
    endtask

    task automatic cmd(input logic [2:0] c);
        @(posedge sys_clk);
        unlock <= 1'b1;
        @(posedge sys_clk);
        unlock <= 1'b0;
        wr(ba(IDX_CMD), {29'h0, c});
    endtask

    task automatic store(input logic [15:0] a);
        @(posedge sys_clk);
        store_valid <= 1'b1;
        store_addr  <= a;
        @(posedge sys_clk);
        store_valid <= 1'b0;
    endtask

    task automatic wait_idle();
        logic [31:0] q;
        logic        e;
        for (int k = 0; k < 100; k++)
        begin
            apb(1'b0, ba(IDX_STATUS), 32'h0, q, e);
            if (q[1:0] === 2'b00)
                break;
        end
        cmp(q[1:0], 2'b00);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    initial
    begin
        logic [31:0] q;
        logic        e;
        {arst_n, psel, penable, pwrite, unlock, debug_access, exec_in_boot} = '0;
        {global_irq_en, store_valid, keep_eeprom_fuse, sleep_req, sleep_idle_mode} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        store_addr = 16'h0000;
        {num_errors, n_compared, cycles} = '0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (i = 0; i < 4; i++)
            rd(ba(4'(i)), 32'h0);
        apb(1'b0, 12'h014, 32'h0, q, e);
        cmp(e, 1'b1);
        apb(1'b1, 12'h001, 32'h1, q, e);
        cmp(e, 1'b1);
        wr(ba(IDX_CMD), 32'h1);
        rd(ba(IDX_STATUS), 32'h0);
        store(16'h1410);
        rd(ba(IDX_ADDR), 32'h1410);
        cmd(CMD_PAGE_WRITE);
        rd(ba(IDX_STATUS), 32'h2);
        cmd(CMD_PAGE_WRITE);
        rd(ba(IDX_STATUS), 32'h6);
        wait_idle();
        rd(ba(IDX_IFLAG), 32'h1);
        wr(ba(IDX_IFLAG), 32'h0);
        rd(ba(IDX_IFLAG), 32'h1);
        wr(ba(IDX_IFLAG), 32'h1);
        rd(ba(IDX_IFLAG), 32'h0);
        global_irq_en <= 1'b1;
        wr(ba(IDX_IEN), 32'h1);
        repeat (3) @(posedge sys_clk);
        cmp(eeprom_ready_irq, 1'b1);
        global_irq_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmp(eeprom_ready_irq, 1'b0);
        wr(ba(IDX_IEN), 32'h0);
        keep_eeprom_fuse <= 1'b1;
        store(16'h8000);
        for (i = 1; i < 7; i++)
        begin
            cmd(3'(i));
            wait_idle();
            rd(ba(IDX_STATUS), 32'h0);
        end
        cmd(CMD_FUSE_PROG);
        wait_idle();
        rd(ba(IDX_STATUS), 32'h4);
        debug_access <= 1'b1;
        wr(ba(IDX_CMD), {29'h0, CMD_FUSE_PROG});
        wait_idle();
        debug_access <= 1'b0;
        rd(ba(IDX_STATUS), 32'h0);
        wr(ba(IDX_PROT), 32'h1);
        wr(ba(IDX_PROT), 32'h0);
        rd(ba(IDX_PROT), 32'h1);
        cmp(app_write_block, 1'b1);
        store(16'h8800);
        cmd(CMD_PAGE_WRITE);
        wait_idle();
        rd(ba(IDX_STATUS), 32'h4);
        wr(ba(IDX_PROT), 32'h3);
        rd(ba(IDX_PROT), 32'h1);
        exec_in_boot <= 1'b1;
        wr(ba(IDX_PROT), 32'h3);
        rd(ba(IDX_PROT), 32'h3);
        cmp(boot_read_blank, 1'b0);
        exec_in_boot <= 1'b0;
        repeat (3) @(posedge sys_clk);
        cmp(boot_read_blank, 1'b1);
        sleep_idle_mode <= 1'b1;
        sleep_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cmp(nvm_asleep, 1'b1);
        sleep_req <= 1'b0;
        store(16'h1410);
        cmd(CMD_PAGE_WRITE);
        sleep_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cmp(clock_hold, 1'b1);
        sleep_req <= 1'b0;
        wait_idle();
        arst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(ba(IDX_PROT), 32'h0);
        summarize();
    end
endmodule
